// *** core/scs_clock_select.sv ***
// System clock source selection, prescaler and digital PLL model with an APB register port.
//
// Behaviour
// - Select 11 drives system clock from external pin
// - Select 10 with bypass divides source by K1
// - K1 reaches division by 1024 at most
// - K1 of one passes source through unchanged
// - Select 10 without bypass uses PLL output
// - PLL output equals input times N over P*K2
// - PLL reference selects oscillator or internal source
// - PLL frequency moves gradually toward lock
// - VCO output divided by K2 gives system clock
// - Band 00 low, 01 high, 1X reserved
// - Select 00 runs from wakeup clock
`timescale 1ns/1ps
`include "scs_consts.svh"

module scs_clock_select (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                external_clock_pin,
  input  wire logic                oscillator_input_pin,
  input  wire logic                internal_clock_source,
  input  wire logic                wakeup_clock_source,
  output logic                     system_clock,
  output logic                     system_clock_tick,
  output scs_pkg::scs_status_t     clock_status
);
  import scs_pkg::*;

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Registers and APB slave.
  //
  // The slave never stretches a transfer, so pready is tied high and every
  // access phase completes at its first rising edge.
  //
  // Read data are captured from the setup phase, so the word is already held
  // in a flip-flop while the access phase is sampled.
  //
  // A write to an unmapped offset is dropped and answered with pslverr, so
  // software that probes the map learns where the map ends.

  logic [1:0]     clock_source_select_r;
  scs_pll_cfg_t   pll_cfg_r;
  logic [9:0]     prescaler_divide_field_r;
  logic [31:0]    prdata_r;
  scs_status_t    status;

  wire            apb_access = psel & penable;
  wire            hit_sys    = paddr == `SCS_ADDR_SYSCFG;
  wire            hit_pll    = paddr == `SCS_ADDR_PLLCFG;
  wire            hit_presc  = paddr == `SCS_ADDR_PRESC;
  wire            hit_stat   = paddr == `SCS_ADDR_STATUS;
  wire            mapped     = hit_sys | hit_pll | hit_presc | hit_stat;
  wire            wr_en      = apb_access & pwrite & mapped;
  wire [1:0]      wr_sel     = pwdata[`SCS_SYSCFG_SEL_LSB +: 2];
  wire [1:0]      wr_band    = pwdata[`SCS_PLL_BAND_LSB +: 2];
  wire [31:0]     rd_mux     = hit_sys   ? {30'h0000_0000, clock_source_select_r} :
                               hit_pll   ? {10'h000, pll_cfg_r.pll_output_divide_field,
                                            pll_cfg_r.pll_feedback_multiply_field,
                                            pll_cfg_r.pll_input_divide_field, pll_cfg_r.vco_band_select,
                                            pll_cfg_r.pll_ref_select, pll_cfg_r.vco_bypass} :
                               hit_presc ? {22'h00_0000, prescaler_divide_field_r} :
                               hit_stat  ? {28'h000_0000, status} : 32'h0000_0000;

  assign pready  = 1'b1;
  assign pslverr = apb_access & ~mapped;
  assign prdata  = prdata_r;

  // The unused select code and the reserved band codes are dropped so the
  // clock tree never enters a configuration it has no path for.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clock_source_select_r    <= `SCS_RST_SEL;
      pll_cfg_r                <= '{`SCS_RST_BYPASS, `SCS_RST_REFSEL, `SCS_RST_BAND,
                                    `SCS_RST_PLL_INPUT_DIVIDE_FIELD, `SCS_RST_PLL_FEEDBACK_MULTIPLY_FIELD, `SCS_RST_PLL_OUTPUT_DIVIDE_FIELD};
      prescaler_divide_field_r <= `SCS_RST_PRESCALER_DIVIDE_FIELD;
      prdata_r                 <= 32'h0000_0000;
    end
    else
    begin
      if (psel && !penable && !pwrite)
        prdata_r <= rd_mux;
      if (wr_en && hit_sys && wr_sel != `SCS_SEL_RSVD)
        clock_source_select_r <= wr_sel;
      if (wr_en && hit_pll)
      begin
        pll_cfg_r.vco_bypass                  <= pwdata[`SCS_PLL_BYPASS_BIT];
        pll_cfg_r.pll_ref_select              <= pwdata[`SCS_PLL_REFSEL_BIT];
        pll_cfg_r.pll_input_divide_field      <= pwdata[`SCS_PLL_PLL_INPUT_DIVIDE_FIELD_LSB +: 4];
        pll_cfg_r.pll_feedback_multiply_field <= pwdata[`SCS_PLL_PLL_FEEDBACK_MULTIPLY_FIELD_LSB +: 8];
        pll_cfg_r.pll_output_divide_field     <= pwdata[`SCS_PLL_PLL_OUTPUT_DIVIDE_FIELD_LSB +: 6];
        if (!wr_band[1])
          pll_cfg_r.vco_band_select <= wr_band;
      end
      if (wr_en && hit_presc)
        prescaler_divide_field_r <= pwdata[`SCS_PRESC_K1_LSB +: 10];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reference choice and prescaler.
  //
  // The reference levels are sampled on pclk, so each of their high and low
  // phases must last at least one pclk cycle or edges are lost.
  //
  // For odd divide factors the divided clock spends the extra edge low, which
  // keeps the counter compare simple at the cost of a slightly uneven duty.

  logic        ref_prev_r;
  logic [10:0] k1_cnt_r;
  logic        k1_out_r;

  wire         ref_clk  = pll_cfg_r.pll_ref_select ? internal_clock_source : oscillator_input_pin;
  wire         ref_edge = rise(ref_clk, ref_prev_r);
  wire [10:0]  k1_val   = {1'b0, prescaler_divide_field_r} + 11'h001;
  wire [10:0]  k1_half  = k1_val >> 1;
  wire [10:0]  k1_next  = (k1_cnt_r == k1_val - 11'h001) ? 11'h000 : k1_cnt_r + 11'h001;
  wire         presc_clk = (prescaler_divide_field_r == 10'h000) ? ref_clk : k1_out_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ref_prev_r <= 1'b0;
      k1_cnt_r   <= 11'h000;
      k1_out_r   <= 1'b0;
    end
    else
    begin
      ref_prev_r <= ref_clk;
      if (ref_edge)
      begin
        k1_cnt_r <= k1_next;
        k1_out_r <= k1_next < k1_half;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Digital PLL: a phase accumulator whose step is trimmed by 64 counts per
  // comparison window, so the output frequency slides and never jumps.
  //
  // The accumulator runs at twice the VCO rate: the output toggles every K2
  // ticks, so one full output period spans 2*K2 ticks and the output frequency
  // is the VCO frequency divided by K2.
  //
  // The trim is a fixed amount per window; a larger trim locks sooner, while a
  // smaller one keeps the residual hunting around the lock point finer.

  logic [15:0] vco_step_r;
  logic [15:0] vco_phase_r;
  logic [3:0]  win_ref_cnt_r;
  logic [15:0] win_vco_cnt_r;
  logic        pll_locked_r;
  logic [5:0]  k2_cnt_r;
  logic        pll_out_r;

  wire         pll_enable = (clock_source_select_r == `SCS_SEL_OSC) & ~pll_cfg_r.vco_bypass;
  wire [16:0]  phase_sum  = {1'b0, vco_phase_r} + {1'b0, vco_step_r};
  wire         vco_tick   = pll_enable & phase_sum[16];
  wire         win_end    = ref_edge & (win_ref_cnt_r == pll_cfg_r.pll_input_divide_field);
  wire [15:0]  n_target   = {7'h00, pll_cfg_r.pll_feedback_multiply_field, 1'b0} + 16'h0002;
  wire [15:0]  band_min   = (pll_cfg_r.vco_band_select == `SCS_BAND_HIGH) ? `SCS_BAND_HIGH_MIN : `SCS_BAND_LOW_MIN;
  wire [15:0]  band_max   = (pll_cfg_r.vco_band_select == `SCS_BAND_HIGH) ? `SCS_BAND_HIGH_MAX : `SCS_BAND_LOW_MAX;
  wire         too_slow   = win_vco_cnt_r < n_target;
  wire         too_fast   = win_vco_cnt_r > n_target;
  wire [15:0]  step_up    = (vco_step_r < band_max - `SCS_PLL_TRIM) ? vco_step_r + `SCS_PLL_TRIM : band_max;
  wire [15:0]  step_dn    = (vco_step_r > band_min + `SCS_PLL_TRIM) ? vco_step_r - `SCS_PLL_TRIM : band_min;
  wire [15:0]  step_clamp = (vco_step_r < band_min) ? band_min : (vco_step_r > band_max) ? band_max : vco_step_r;
  wire         k2_wrap    = k2_cnt_r == pll_cfg_r.pll_output_divide_field;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vco_step_r    <= `SCS_BAND_LOW_MIN;
      vco_phase_r   <= 16'h0000;
      win_ref_cnt_r <= 4'h0;
      win_vco_cnt_r <= 16'h0000;
      pll_locked_r  <= 1'b0;
      k2_cnt_r      <= 6'h00;
      pll_out_r     <= 1'b0;
    end
    else if (!pll_enable)
    begin
      vco_phase_r   <= 16'h0000;
      win_ref_cnt_r <= 4'h0;
      win_vco_cnt_r <= 16'h0000;
      pll_locked_r  <= 1'b0;
      k2_cnt_r      <= 6'h00;
      pll_out_r     <= 1'b0;
      vco_step_r    <= step_clamp;
    end
    else
    begin
      vco_phase_r <= phase_sum[15:0];
      if (win_end)
      begin
        win_ref_cnt_r <= 4'h0;
        win_vco_cnt_r <= {15'h0000, vco_tick};
        pll_locked_r  <= ~too_slow & ~too_fast;
        vco_step_r    <= too_slow ? step_up : too_fast ? step_dn : step_clamp;
      end
      else
      begin
        if (ref_edge)
          win_ref_cnt_r <= win_ref_cnt_r + 4'h1;
        if (vco_tick)
          win_vco_cnt_r <= win_vco_cnt_r + 16'h0001;
      end
      // Each output half period spans K2 VCO ticks.
      if (vco_tick)
      begin
        k2_cnt_r <= k2_wrap ? 6'h00 : k2_cnt_r + 6'h01;
        if (k2_wrap)
          pll_out_r <= ~pll_out_r;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Glitch-free output switch: park low until both old and new paths are low.
  //
  // Parking costs a few cycles of a held-low clock on every select change; in return
  // no phase is shortened, except a PLL high phase, which a write leaving select 10
  // cuts by clearing pll_out_r; a vco_bypass write under select 10 changes path unparked.
  //
  // The tick is derived from the registered clock itself, so it trails each
  // rising edge of system_clock by exactly one cycle.

  scs_mux_state_t mux_state_r;
  logic [1:0]     active_sel_r;
  logic           sys_clk_r;
  logic           tick_r;
  logic           sys_prev_r;

  function automatic logic path_level(input logic [1:0] sel, input logic byp,
                                      input logic ext, input logic pre, input logic pll, input logic wu);
    case (sel)
      `SCS_SEL_DIRECT: path_level = ext;
      `SCS_SEL_OSC:    path_level = byp ? pre : pll;
      default:         path_level = wu;
    endcase
  endfunction

  wire cur_level = path_level(active_sel_r, pll_cfg_r.vco_bypass, external_clock_pin, presc_clk,
                              pll_out_r, wakeup_clock_source);
  wire new_level = path_level(clock_source_select_r, pll_cfg_r.vco_bypass, external_clock_pin, presc_clk,
                              pll_out_r, wakeup_clock_source);
  wire sel_change = active_sel_r != clock_source_select_r;
  wire clk_nxt    = (mux_state_r == SCS_RUN) ? cur_level : 1'b0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mux_state_r  <= SCS_RUN;
      active_sel_r <= `SCS_RST_SEL;
      sys_clk_r    <= 1'b0;
      sys_prev_r   <= 1'b0;
      tick_r       <= 1'b0;
    end
    else
    begin
      case (mux_state_r)
        SCS_RUN:
          if (sel_change && !cur_level)
            mux_state_r <= SCS_PARK;
        SCS_PARK:
          if (!new_level)
          begin
            active_sel_r <= clock_source_select_r;
            mux_state_r  <= SCS_RUN;
          end
        default:
          mux_state_r <= SCS_RUN;
      endcase
      sys_clk_r  <= (mux_state_r == SCS_RUN && sel_change && !cur_level) ? 1'b0 : clk_nxt;
      sys_prev_r <= sys_clk_r;
      tick_r     <= rise(sys_clk_r, sys_prev_r);
    end
  end

  assign status.active_source = active_sel_r;
  assign status.pll_locked    = pll_locked_r;
  assign status.switch_parked = mux_state_r == SCS_PARK;

  assign system_clock      = sys_clk_r;
  assign system_clock_tick = tick_r;
  assign clock_status      = status;

endmodule

// *** core/scs_consts.svh ***
// Register offsets, field positions, reset values and limits of the system clock selector.
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

`define SCS_ADDR_SYSCFG      12'h000
`define SCS_ADDR_PLLCFG      12'h004
`define SCS_ADDR_PRESC       12'h008
`define SCS_ADDR_STATUS      12'h00C

`define SCS_SEL_WAKEUP       2'b00
`define SCS_SEL_RSVD         2'b01
`define SCS_SEL_OSC          2'b10
`define SCS_SEL_DIRECT       2'b11

`define SCS_SYSCFG_SEL_LSB   0
`define SCS_PLL_BYPASS_BIT   0
`define SCS_PLL_REFSEL_BIT   1
`define SCS_PLL_BAND_LSB     2
`define SCS_PLL_PLL_INPUT_DIVIDE_FIELD_LSB     4
`define SCS_PLL_PLL_FEEDBACK_MULTIPLY_FIELD_LSB     8
`define SCS_PLL_PLL_OUTPUT_DIVIDE_FIELD_LSB    16
`define SCS_PRESC_K1_LSB     0

`define SCS_RST_SEL          2'b00
`define SCS_RST_BYPASS       1'b1
`define SCS_RST_REFSEL       1'b0
`define SCS_RST_BAND         2'b00
`define SCS_RST_PLL_INPUT_DIVIDE_FIELD         4'h0
`define SCS_RST_PLL_FEEDBACK_MULTIPLY_FIELD         8'h03
`define SCS_RST_PLL_OUTPUT_DIVIDE_FIELD        6'h00
`define SCS_RST_PRESCALER_DIVIDE_FIELD        10'h000

`define SCS_BAND_LOW         2'b00
`define SCS_BAND_HIGH        2'b01
`define SCS_BAND_LOW_MIN     16'h0100
`define SCS_BAND_LOW_MAX     16'h2400
`define SCS_BAND_HIGH_MIN    16'h2000
`define SCS_BAND_HIGH_MAX    16'h3400
`define SCS_PLL_TRIM         16'h0040

`endif

// *** core/scs_pkg.sv ***
// Types shared by the system clock selector.
package scs_pkg;

  typedef struct packed {
    logic       vco_bypass;
    logic       pll_ref_select;
    logic [1:0] vco_band_select;
    logic [3:0] pll_input_divide_field;
    logic [7:0] pll_feedback_multiply_field;
    logic [5:0] pll_output_divide_field;
  } scs_pll_cfg_t;

  typedef struct packed {
    logic [1:0] active_source;
    logic       pll_locked;
    logic       switch_parked;
  } scs_status_t;

  typedef enum logic [0:0] {
    SCS_RUN  = 1'b0,
    SCS_PARK = 1'b1
  } scs_mux_state_t;

endpackage

// *** testbench/scs_clock_select_sva.sv ***
// Port checker for the system clock selector.
`timescale 1ns/1ps
module scs_clock_select_sva (
  input logic                 pclk,
  input logic                 presetn,
  input logic                 psel,
  input logic                 penable,
  input logic [11:0]          paddr,
  input logic                 pslverr,
  input logic                 external_clock_pin,
  input logic                 wakeup_clock_source,
  input logic                 system_clock,
  input logic                 system_clock_tick,
  input scs_pkg::scs_status_t clock_status
);
  import scs_pkg::*;
  ////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Following is judged only after a path has run two cycles, so the switch latency never fires it.
  wire run_ext = clock_status.active_source == 2'b11 && !clock_status.switch_parked;
  wire run_wu  = clock_status.active_source == 2'b00 && !clock_status.switch_parked;
  AST_DIRECT_FOLLOW: assert property (run_ext && $past(run_ext) && $past(presetn)
    |-> system_clock == $past(external_clock_pin)) else $error("direct clock not followed");
  AST_WAKEUP_FOLLOW: assert property (run_wu && $past(run_wu) && $past(presetn)
    |-> system_clock == $past(wakeup_clock_source)) else $error("wakeup clock not followed");
  AST_PARK_LOW: assert property (clock_status.switch_parked && $past(clock_status.switch_parked)
    |-> !system_clock) else $error("clock not low while parked");
  AST_PARK_BEFORE_SWITCH: assert property ($changed(clock_status.active_source)
    |-> $past(clock_status.switch_parked)) else $error("source changed without parking");
  AST_TICK_AFTER_RISE: assert property ($rose(system_clock) |=> system_clock_tick)
    else $error("tick missing after rise");
  AST_TICK_PULSE: assert property (system_clock_tick |=> !system_clock_tick)
    else $error("tick longer than one cycle");
  AST_NO_RSVD_SRC: assert property (clock_status.active_source != 2'b01)
    else $error("reserved source active");
  AST_SLVERR: assert property (psel && penable |-> pslverr == (paddr != 12'h000 && paddr != 12'h004 &&
    paddr != 12'h008 && paddr != 12'h00C))
    else $error("error response wrong");
  cover property (run_ext);
  cover property ($rose(clock_status.switch_parked));
  cover property (pslverr);
endmodule

// *** testbench/tb_top.sv ***
// Self-checking testbench for the system clock selector.
`timescale 1ns/1ps
module tb_top;
  import scs_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic        pready, pslverr, system_clock, system_clock_tick, e;
  logic [3:0]  cnt = 4'h0;
  wire         external_clock_pin, oscillator_input_pin, internal_clock_source, wakeup_clock_source;
  scs_status_t clock_status;
  int          miscompares = 0;
  int          checks = 0;
  int          n;
  ////////////////////////////////////////
  initial forever #10 pclk = ~pclk;
  // One counter gives all sources; periods are 2, 4, 8 and 16 cycles, slow enough to be sampled.
  always @(posedge pclk) cnt <= cnt + 4'h1;
  assign {wakeup_clock_source, internal_clock_source, external_clock_pin, oscillator_input_pin} = cnt;
  scs_clock_select i_dut (.*);
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic guard(input int i, input int lim);
    if (i >= lim)
    begin
      miscompares++;
      report_and_stop;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    guard(i, 16);
    e = pslverr;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Waits for a settled source, or for lock when lk is set; polled off the edge to avoid races.
  task automatic waitc(input logic [1:0] s, input logic lk, input int lim);
    int i;
    for (i = 0; i < lim; i++)
    begin
      @(negedge pclk);
      if (lk ? clock_status.pll_locked === 1'b1
             : clock_status.active_source === s && clock_status.switch_parked === 1'b0)
        break;
    end
    guard(i, lim);
    @(posedge pclk);
  endtask
  task automatic rises(input int cyc, input int exp, input int tol);
    logic p;
    repeat (cyc) @(negedge pclk);
    n = 0;
    p = system_clock;
    repeat (cyc)
    begin
      @(negedge pclk);
      if (system_clock === 1'b1 && p === 1'b0)
        n++;
      p = system_clock;
    end
    chk((n > exp - tol && n < exp + tol) ? exp : n, exp);
    @(posedge pclk);
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 12'(i * 4), 32'h0000_0000);
      chk(q, (i == 1) ? 32'h0000_0301 : 32'h0000_0000);
    end
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(e, 32'h0000_0001);
    chk(q, 32'h0000_0000);
  endtask
  task automatic t_direct;
    apb(1'b1, 12'h000, 32'h0000_0003);
    waitc(2'b11, 1'b0, 500);
    rises(64, 16, 1);
    apb(1'b1, 12'h000, 32'h0000_0001);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(q, 32'h0000_0003);
  endtask
  task automatic t_presc;
    logic [15:0] tab [5][4] = '{'{16'h0301, 16'h0000, 16'h0060, 16'h0030},
      '{16'h0301, 16'h0002, 16'h0060, 16'h0010}, '{16'h0301, 16'h0003, 16'h0060, 16'h000C},
      '{16'h0301, 16'h03FF, 16'h1000, 16'h0002}, '{16'h0303, 16'h0000, 16'h0060, 16'h000C}};
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, 12'h004, {16'h0000, tab[i][0]});
      apb(1'b1, 12'h008, {16'h0000, tab[i][1]});
      apb(1'b1, 12'h000, 32'h0000_0002);
      waitc(2'b10, 1'b0, 3000);
      rises(tab[i][2], tab[i][3], 1);
    end
  endtask
  task automatic t_wakeup;
    apb(1'b1, 12'h000, 32'h0000_0000);
    waitc(2'b00, 1'b0, 500);
    rises(96, 6, 1);
  endtask
  task automatic t_pll;
    // Internal reference of 8 cycles, P 4, N 1, K2 1: one output period per 32 cycles.
    apb(1'b1, 12'h004, 32'h0000_003A);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(q, 32'h0000_0032);
    apb(1'b1, 12'h000, 32'h0000_0002);
    waitc(2'b10, 1'b1, 40000);
    rises(800, 25, 4);
  endtask
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_direct;
    t_presc;
    t_wakeup;
    t_pll;
    report_and_stop;
  end
endmodule
bind scs_clock_select scs_clock_select_sva i_sva (.*);
